// ---- common/idc_pkg.sv ----
package idc_pkg;
	// ****************************************
	// Packet shape
	// ****************************************
	localparam int SLOTS = 8;
	localparam int REG_AW = 6;
	localparam int PRED_CNT = 8;
	localparam int PRED_AW = 3;
	localparam int STAGES = 2;
	localparam int STG_DISPATCH = 0;
	localparam int STG_DECODE = 1;
	// ****************************************
	// Drain timing
	// ****************************************
	localparam int DRAIN_CYCLES = 4;
	localparam int DRAIN_CW = 4;
	localparam logic EXC_ENABLE_ON = 1'b1;
	localparam logic [PRED_CNT-1:0] PRED_RST = 8'h00;
	// ****************************************
	// Control states
	// ****************************************
	typedef enum logic [2:0] {
		ST_RUN = 3'b001,
		ST_DRAIN = 3'b010,
		ST_HANDLER = 3'b100
	} idc_state_t;
endpackage

// ---- rtl/idc_slot_qual.sv ----
`timescale 1ns/10ps
module idc_slot_qual #(
	parameter int PRED_CNT = 8,
	parameter int PRED_AW = 3
) (
	input wire logic slot_vld,
	input wire logic pred_use,
	input wire logic [PRED_AW-1:0] pred_idx,
	input wire logic pred_inv,
	input wire logic [PRED_CNT-1:0] pred_val,
	input wire logic annul,
	output logic wr_eff
);
	// Condition is judged on committed predicates only, so an annulled
	// predicate write can never steer a later slot
	always_comb
	begin
		wr_eff = slot_vld && !annul;
		if (pred_use)
		begin
			wr_eff = wr_eff && (pred_val[pred_idx] ^ pred_inv);
		end
	end
endmodule // idc_slot_qual

// ---- rtl/idc_drain_check.sv ----
`timescale 1ns/10ps
// Function
// - Exceptions are raised only while global_exception_enable is one.
// - Taking an interrupt drains the pipe, annulling all not yet in first_execute_phase.
// - Packets in decode_stage and dispatch_stage at drain start are annulled.
// - Two writes to one register in one cycle raise a conflict exception.
// - Annulled writes never conflict, nor steer predicates of later packets.
module idc_drain_check #(
	parameter int SLOTS = idc_pkg::SLOTS,
	parameter int REG_AW = idc_pkg::REG_AW,
	parameter int DRAIN_CYCLES = idc_pkg::DRAIN_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic irq_req,
	input wire logic global_exception_enable,
	input wire logic in_vld,
	input wire logic [SLOTS-1:0] in_slot_vld,
	input wire logic [SLOTS-1:0][REG_AW-1:0] in_slot_dst,
	input wire logic [SLOTS-1:0] in_slot_dat,
	input wire logic [SLOTS-1:0] in_pred_use,
	input wire logic [SLOTS-1:0][idc_pkg::PRED_AW-1:0] in_pred_idx,
	input wire logic [SLOTS-1:0] in_pred_inv,
	input wire logic late_wr_vld,
	input wire logic [REG_AW-1:0] late_wr_dst,
	input wire logic late_wr_dat,
	input wire logic exc_clear,
	output logic in_ready,
	output logic [SLOTS-1:0] wb_en,
	output logic [SLOTS-1:0][REG_AW-1:0] wb_dst,
	output logic [SLOTS-1:0] wb_dat,
	output logic [idc_pkg::PRED_CNT-1:0] pred_state,
	output logic draining,
	output logic handler_enter,
	output logic conflict_exc,
	output logic exc_flag
);
	// ****************************************
	// Declarations
	// ****************************************
	idc_pkg::idc_state_t state_reg;
	idc_pkg::idc_state_t state_next;
	logic irq_s1_reg;
	logic irq_s2_reg;
	logic irq_s3_reg;
	logic irq_edge;
	logic annul_now;
	logic accept;
	logic [idc_pkg::DRAIN_CW-1:0] drain_cnt_reg;
	logic [idc_pkg::STAGES-1:0] pk_vld_reg;
	logic [idc_pkg::STAGES-1:0][SLOTS-1:0] sl_vld_reg;
	logic [idc_pkg::STAGES-1:0][SLOTS-1:0][REG_AW-1:0] sl_dst_reg;
	logic [idc_pkg::STAGES-1:0][SLOTS-1:0] sl_dat_reg;
	logic [idc_pkg::STAGES-1:0][SLOTS-1:0] sl_pu_reg;
	logic [idc_pkg::STAGES-1:0][SLOTS-1:0][idc_pkg::PRED_AW-1:0] sl_pi_reg;
	logic [idc_pkg::STAGES-1:0][SLOTS-1:0] sl_inv_reg;
	logic [idc_pkg::PRED_CNT-1:0] pred_reg;
	logic [idc_pkg::PRED_CNT-1:0] pred_next;
	logic [SLOTS-1:0] eff;
	logic conflict;
	logic [SLOTS-1:0] wb_en_reg;
	logic [SLOTS-1:0][REG_AW-1:0] wb_dst_reg;
	logic [SLOTS-1:0] wb_dat_reg;
	logic in_ready_reg;
	logic draining_reg;
	logic handler_enter_reg;
	logic conflict_exc_reg;
	logic exc_flag_reg;
	// ****************************************
	// Interrupt request synchroniser
	// ****************************************
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			irq_s1_reg <= 1'b0;
			irq_s2_reg <= 1'b0;
			irq_s3_reg <= 1'b0;
		end
		else
		begin
			irq_s1_reg <= irq_req;
			irq_s2_reg <= irq_s1_reg;
			irq_s3_reg <= irq_s2_reg;
		end
	end
	assign irq_edge = irq_s2_reg && !irq_s3_reg;
	// Drain start cycle already annuls the decode packet about to enter execute
	assign annul_now = (state_reg == idc_pkg::ST_RUN && irq_edge) || state_reg == idc_pkg::ST_DRAIN;
	assign accept = in_vld && in_ready_reg && !annul_now;
	// ****************************************
	// Control state machine
	// ****************************************
	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			idc_pkg::ST_RUN:
			begin
				if (irq_edge)
				begin
					state_next = idc_pkg::ST_DRAIN;
				end
			end
			idc_pkg::ST_DRAIN:
			begin
				if (drain_cnt_reg == idc_pkg::DRAIN_CW'(1))
				begin
					state_next = idc_pkg::ST_HANDLER;
				end
			end
			idc_pkg::ST_HANDLER:
			begin
				state_next = idc_pkg::ST_RUN;
			end
			default:
			begin
				state_next = idc_pkg::ST_RUN;
			end
		endcase
	end
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg <= idc_pkg::ST_RUN;
			drain_cnt_reg <= '0;
			in_ready_reg <= 1'b1;
			draining_reg <= 1'b0;
			handler_enter_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			if (state_reg == idc_pkg::ST_RUN && irq_edge)
			begin
				drain_cnt_reg <= idc_pkg::DRAIN_CW'(DRAIN_CYCLES);
			end
			else if (drain_cnt_reg != '0)
			begin
				drain_cnt_reg <= drain_cnt_reg - idc_pkg::DRAIN_CW'(1);
			end
			in_ready_reg <= (state_next == idc_pkg::ST_RUN) && !(state_reg == idc_pkg::ST_RUN && irq_edge);
			draining_reg <= state_next == idc_pkg::ST_DRAIN;
			// Handler is entered plainly; the flag only moves on a real conflict or on exc_clear
			handler_enter_reg <= state_reg == idc_pkg::ST_DRAIN && state_next == idc_pkg::ST_HANDLER;
		end
	end

	// ****************************************
	// Dispatch and decode stages
	// ****************************************
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pk_vld_reg <= '0;
			sl_vld_reg <= '0;
			sl_dst_reg <= '0;
			sl_dat_reg <= '0;
			sl_pu_reg <= '0;
			sl_pi_reg <= '0;
			sl_inv_reg <= '0;
		end
		else if (annul_now)
		begin
			pk_vld_reg <= '0;
			sl_vld_reg <= '0;
		end
		else
		begin
			pk_vld_reg[idc_pkg::STG_DISPATCH] <= accept;
			sl_vld_reg[idc_pkg::STG_DISPATCH] <= accept ? in_slot_vld : '0;
			sl_dst_reg[idc_pkg::STG_DISPATCH] <= in_slot_dst;
			sl_dat_reg[idc_pkg::STG_DISPATCH] <= in_slot_dat;
			sl_pu_reg[idc_pkg::STG_DISPATCH] <= in_pred_use;
			sl_pi_reg[idc_pkg::STG_DISPATCH] <= in_pred_idx;
			sl_inv_reg[idc_pkg::STG_DISPATCH] <= in_pred_inv;
			pk_vld_reg[idc_pkg::STG_DECODE] <= pk_vld_reg[idc_pkg::STG_DISPATCH];
			sl_vld_reg[idc_pkg::STG_DECODE] <= sl_vld_reg[idc_pkg::STG_DISPATCH];
			sl_dst_reg[idc_pkg::STG_DECODE] <= sl_dst_reg[idc_pkg::STG_DISPATCH];
			sl_dat_reg[idc_pkg::STG_DECODE] <= sl_dat_reg[idc_pkg::STG_DISPATCH];
			sl_pu_reg[idc_pkg::STG_DECODE] <= sl_pu_reg[idc_pkg::STG_DISPATCH];
			sl_pi_reg[idc_pkg::STG_DECODE] <= sl_pi_reg[idc_pkg::STG_DISPATCH];
			sl_inv_reg[idc_pkg::STG_DECODE] <= sl_inv_reg[idc_pkg::STG_DISPATCH];
		end
	end

	// ****************************************
	// Entry into the first execute phase
	// ****************************************
	genvar gi;
	generate
		for (gi = 0; gi < SLOTS; gi++)
		begin : g_slot
			idc_slot_qual #(
				.PRED_CNT(idc_pkg::PRED_CNT),
				.PRED_AW(idc_pkg::PRED_AW)
			) u_qual (
				.slot_vld(sl_vld_reg[idc_pkg::STG_DECODE][gi] && pk_vld_reg[idc_pkg::STG_DECODE]),
				.pred_use(sl_pu_reg[idc_pkg::STG_DECODE][gi]),
				.pred_idx(sl_pi_reg[idc_pkg::STG_DECODE][gi]),
				.pred_inv(sl_inv_reg[idc_pkg::STG_DECODE][gi]),
				.pred_val(pred_reg),
				.annul(annul_now),
				.wr_eff(eff[gi])
			);
		end
	endgenerate
	// ****************************************
	// Same-cycle write conflict and predicate commit
	// ****************************************
	// Only surviving writes are compared; long-latency writes landing now count too
	always_comb
	begin
		conflict = 1'b0;
		pred_next = pred_reg;
		for (int i = 0; i < SLOTS; i++)
		begin
			if (eff[i] && late_wr_vld && sl_dst_reg[idc_pkg::STG_DECODE][i] == late_wr_dst)
			begin
				conflict = 1'b1;
			end
			for (int j = i + 1; j < SLOTS; j++)
			begin
				if (eff[i] && eff[j] && sl_dst_reg[idc_pkg::STG_DECODE][i] == sl_dst_reg[idc_pkg::STG_DECODE][j])
				begin
					conflict = 1'b1;
				end
			end
		end
		if (late_wr_vld && late_wr_dst < REG_AW'(idc_pkg::PRED_CNT))
		begin
			pred_next[late_wr_dst[idc_pkg::PRED_AW-1:0]] = late_wr_dat;
		end
		for (int i = 0; i < SLOTS; i++)
		begin
			if (eff[i] && sl_dst_reg[idc_pkg::STG_DECODE][i] < REG_AW'(idc_pkg::PRED_CNT))
			begin
				pred_next[sl_dst_reg[idc_pkg::STG_DECODE][i][idc_pkg::PRED_AW-1:0]] = sl_dat_reg[idc_pkg::STG_DECODE][i];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pred_reg <= idc_pkg::PRED_RST;
			wb_en_reg <= '0;
			wb_dst_reg <= '0;
			wb_dat_reg <= '0;
		end
		else
		begin
			pred_reg <= pred_next;
			wb_en_reg <= eff;
			wb_dst_reg <= sl_dst_reg[idc_pkg::STG_DECODE];
			wb_dat_reg <= sl_dat_reg[idc_pkg::STG_DECODE];
		end
	end

	// ****************************************
	// Exception reporting
	// ****************************************
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			conflict_exc_reg <= 1'b0;
			exc_flag_reg <= 1'b0;
		end
		else
		begin
			conflict_exc_reg <= conflict && global_exception_enable == idc_pkg::EXC_ENABLE_ON;
			// Set beats clear so a conflict in the clearing cycle is kept
			if (conflict && global_exception_enable == idc_pkg::EXC_ENABLE_ON)
			begin
				exc_flag_reg <= 1'b1;
			end
			else if (exc_clear)
			begin
				exc_flag_reg <= 1'b0;
			end
		end
	end
	assign in_ready = in_ready_reg;
	assign wb_en = wb_en_reg;
	assign wb_dst = wb_dst_reg;
	assign wb_dat = wb_dat_reg;
	assign pred_state = pred_reg;
	assign draining = draining_reg;
	assign handler_enter = handler_enter_reg;
	assign conflict_exc = conflict_exc_reg;
	assign exc_flag = exc_flag_reg;
endmodule // idc_drain_check

// ---- tb/idc_drain_check_sva.sv ----
`timescale 1ns/10ps
module idc_drain_check_sva #(
	parameter int SLOTS = 8,
	parameter int DRAIN_CYCLES = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic irq_req,
	input wire logic global_exception_enable,
	input wire logic exc_clear,
	input wire logic in_ready,
	input wire logic [SLOTS-1:0] wb_en,
	input wire logic draining,
	input wire logic handler_enter,
	input wire logic conflict_exc,
	input wire logic exc_flag
);
	// **********
	// Drain and conflict properties
	// **********
	logic [7:0] dr_cnt_reg;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			dr_cnt_reg <= 8'h00;
		else
			dr_cnt_reg <= draining ? dr_cnt_reg + 8'h01 : 8'h00;
	sequence irq_in_run;
		$rose(irq_req) && in_ready && !draining;
	endsequence
	sequence hand_off;
		##[0:1] handler_enter ##1 !handler_enter;
	endsequence
	a_irq_starts_drain: assert property (irq_in_run |-> ##[1:4] draining)
		else $error("interrupt did not start a drain");
	a_drain_len_exact: assert property ($fell(draining) |-> dr_cnt_reg == DRAIN_CYCLES)
		else $error("drain length wrong");
	a_drain_ends_handler: assert property ($fell(draining) |-> hand_off)
		else $error("no single handler entry after drain");
	a_drain_no_write: assert property (draining |-> wb_en == '0 && !conflict_exc)
		else $error("write or conflict during drain");
	a_drain_stalls_input: assert property (draining |-> !in_ready)
		else $error("packets accepted during drain");
	a_drain_no_flag: assert property (draining && $past(draining) |-> !$rose(exc_flag))
		else $error("flag raised by annulled packet");
	a_enable_gates_exc: assert property (!global_exception_enable && !$past(global_exception_enable)
		|-> !conflict_exc && !$rose(exc_flag))
		else $error("exception while disabled");
	a_exc_sets_flag: assert property (conflict_exc |-> exc_flag && wb_en != '0)
		else $error("conflict without flag or write");
	a_flag_stays_set: assert property (exc_flag && !exc_clear |=> exc_flag)
		else $error("flag dropped without clear");
endmodule // idc_drain_check_sva
bind idc_drain_check idc_drain_check_sva #(.SLOTS(SLOTS), .DRAIN_CYCLES(DRAIN_CYCLES)) idc_drain_check_sva_i (
	.clk, .rst_n, .irq_req, .global_exception_enable, .exc_clear, .in_ready, .wb_en, .draining, .handler_enter,
	.conflict_exc, .exc_flag);

// ---- tb/idc_irq_src.sv ----
`timescale 1ns/10ps
module idc_irq_src (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic fire,
	input wire logic clear,
	input wire logic handler_enter,
	output logic irq_req,
	output logic exc_clear
);
	// **********
	// Interrupt source and handler software
	// **********
	// Level request held until serviced, as a real source would
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
		begin
			irq_req <= 1'b0;
			exc_clear <= 1'b0;
		end
		else
		begin
			irq_req <= fire | (irq_req & ~handler_enter);
			exc_clear <= clear;
		end
endmodule // idc_irq_src

// ---- tb/tb.sv ----
`timescale 1ns/10ps
module tb;
	// **********
	// Bench
	// **********
	logic clk = 1'b0, rst_n = 1'b0, global_exception_enable = 1'b1, in_vld = 1'b0, fire = 1'b0, clear = 1'b0;
	logic late_wr_vld = 1'b0, late_wr_dat = 1'b0, irq_req, exc_clear, in_ready, draining, handler_enter;
	logic conflict_exc, exc_flag;
	logic [7:0] in_slot_vld = 8'h00, in_slot_dat = 8'h00, in_pred_use = 8'h00, in_pred_inv = 8'h00;
	logic [7:0] wb_en, wb_dat, pred_state;
	logic [7:0][5:0] in_slot_dst = '0, wb_dst;
	logic [7:0][2:0] in_pred_idx = '0;
	logic [5:0] late_wr_dst = 6'h00;
	int mismatches = 0, samples_checked = 0, cycles = 0;
	always #5 clk = ~clk;
	idc_drain_check idc_drain_check_i (.clk, .rst_n, .irq_req, .global_exception_enable, .in_vld, .in_slot_vld,
		.in_slot_dst, .in_slot_dat, .in_pred_use, .in_pred_idx, .in_pred_inv, .late_wr_vld, .late_wr_dst,
		.late_wr_dat, .exc_clear, .in_ready, .wb_en, .wb_dst, .wb_dat, .pred_state, .draining, .handler_enter,
		.conflict_exc, .exc_flag);
	idc_irq_src idc_irq_src_i (.clk, .rst_n, .fire, .clear, .handler_enter, .irq_req, .exc_clear);
	task automatic chk(input logic ok, input string m);
		samples_checked++;
		if (ok !== 1'b1)
		begin
			mismatches++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask
	task automatic idle(input string n);
		in_slot_vld = 8'h00;
		in_pred_use = 8'h00;
		in_pred_inv = 8'h00;
		late_wr_vld = 1'b0;
		@(negedge clk);
		$display("%s done", n);
	endtask
	// Write-back shows two edges after the taking edge
	task automatic issue;
		in_vld = 1'b1;
		@(negedge clk);
		in_vld = 1'b0;
		repeat (2) @(negedge clk);
	endtask
	task automatic t_write;
		in_slot_vld = 8'h03;
		in_slot_dst[0] = 6'h14;
		in_slot_dst[1] = 6'h03;
		in_slot_dat = 8'h03;
		issue();
		chk(wb_en === 8'h03 && wb_dst[0] === 6'h14 && wb_dat === 8'h03, "write back");
		chk(pred_state === 8'h08 && conflict_exc === 1'b0, "predicate commit");
		idle("write");
	endtask
	// Late write is held over the whole flight, so its landing cycle need not be known
	task automatic t_conflict(input logic late);
		in_slot_vld = late ? 8'h01 : 8'h03;
		in_slot_dst[0] = 6'h1e;
		in_slot_dst[1] = 6'h1e;
		late_wr_vld = late;
		late_wr_dst = 6'h1e;
		issue();
		chk(wb_en === in_slot_vld && exc_flag === 1'b1 && conflict_exc === 1'b1, "conflict flag");
		late_wr_vld = 1'b0;
		clear = 1'b1;
		@(negedge clk);
		clear = 1'b0;
		repeat (2) @(negedge clk);
		chk(exc_flag === 1'b0, "flag clear");
		idle("conflict");
	endtask
	task automatic t_gee_off;
		global_exception_enable = 1'b0;
		@(negedge clk);
		in_slot_vld = 8'h03;
		issue();
		chk(wb_en === 8'h03 && conflict_exc === 1'b0 && exc_flag === 1'b0, "masked conflict");
		idle("disabled");
		global_exception_enable = 1'b1;
	endtask
	// First packet would set a predicate but is annulled, second would conflict on the old value
	task automatic t_drain;
		int hs = 0;
		int dr = 0;
		fire = 1'b1;
		@(negedge clk);
		fire = 1'b0;
		in_vld = 1'b1;
		in_slot_vld = 8'h01;
		in_slot_dst[0] = 6'h05;
		in_slot_dat = 8'h01;
		@(negedge clk);
		in_slot_vld = 8'h03;
		in_slot_dst[0] = 6'h28;
		in_slot_dst[1] = 6'h28;
		in_pred_use = 8'h03;
		in_pred_inv = 8'h03;
		in_pred_idx[0] = 3'h5;
		in_pred_idx[1] = 3'h5;
		// Second packet is taken here; a third offer would only be refused
		@(negedge clk);
		in_vld = 1'b0;
		repeat (20)
		begin
			@(negedge clk);
			chk(wb_en === 8'h00 && conflict_exc === 1'b0, "annulled write seen");
			dr += int'(draining === 1'b1);
			hs += int'(handler_enter === 1'b1);
		end
		chk(hs == 1 && dr == idc_pkg::DRAIN_CYCLES, "drain shape");
		chk(pred_state === 8'h08 && exc_flag === 1'b0 && in_ready === 1'b1, "handler entry");
		// Committed predicates steer slots: slot 0 on a set one, slot 1 on a clear one
		in_pred_idx[0] = 3'h3;
		in_pred_inv = 8'h00;
		issue();
		chk(wb_en === 8'h01 && conflict_exc === 1'b0 && exc_flag === 1'b0, "predicated write");
		idle("drain");
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (8) @(negedge clk);
		chk(in_ready === 1'b1 && wb_en === 8'h00 && pred_state === 8'h00, "reset values");
		rst_n = 1'b1;
		@(negedge clk);
		t_write();
		t_conflict(1'b0);
		t_conflict(1'b1);
		t_gee_off();
		t_drain();
		final_report();
	end
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			mismatches++;
			final_report();
		end
	end
endmodule // tb
